// [core_instruction_length_timing.sv]
`default_nettype none
module core_instruction_length_timing
    import core_timing_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic code_valid_in,
    input wire logic [OPC_W-1:0] code_byte_in,
    output logic code_ready_out,
    output logic instr_start_out,
    output logic instr_done_out,
    output logic [OPC_W-1:0] instr_opcode_out,
    output logic [OPS_W-1:0] instr_operands_out,
    output logic [LEN_W-1:0] instr_length_out,
    output logic [CYC_W-1:0] instr_cycles_out,
    output logic [9:0] instr_class_out,
    output logic instr_covered_out,
    output logic instr_reserved_out,
    output logic operand_stall_out,
    output logic aux_onchip_out,
    output logic ext_mem_req_out
);

    // table entry helper
    function automatic timing_t ent(
        input logic [LEN_W-1:0] len,
        input logic [CYC_W-1:0] cyc,
        input cls_t cls
    );
        timing_t t;
        t.covered = 1'b1;
        t.len = len;
        t.cyc = cyc;
        t.cls = cls;
        return t;
    endfunction

    // regular accumulator rows: immediate, direct, indirect, register
    function automatic timing_t alu_row(
        input logic [3:0] lo,
        input cls_t cls
    );
        timing_t t;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        if (lo == LO_IMM)
            t = ent(LEN_2, CYC_2, cls);
        else if (lo == LO_DIR)
            t = ent(LEN_2, CYC_3, cls);
        else if (lo == LO_IND0 || lo == LO_IND1)
            t = ent(LEN_1, CYC_3, cls);
        else if (lo[3])
            t = ent(LEN_1, CYC_2, cls);
        return t;
    endfunction

    // logic rows also write a direct byte
    function automatic timing_t logic_row(
        input logic [3:0] lo
    );
        timing_t t;
        t = alu_row(lo, CLS_LOGIC);
        if (lo == LO_DIR_ACC)
            t = ent(LEN_2, CYC_4, CLS_LOGIC);
        else if (lo == LO_DIR_IMM)
            t = ent(LEN_3, CYC_4, CLS_LOGIC);
        return t;
    endfunction

    // data transfer group
    function automatic timing_t move_row(
        input logic [OPC_W-1:0] op
    );
        timing_t t;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        casez (op)
            8'b1110_1???: t = ent(LEN_1, CYC_1, CLS_MOVE);
            8'he5: t = ent(LEN_2, CYC_2, CLS_MOVE);
            8'b1110_011?: t = ent(LEN_1, CYC_2, CLS_MOVE);
            8'h74: t = ent(LEN_2, CYC_2, CLS_MOVE);
            8'b1111_1???: t = ent(LEN_1, CYC_2, CLS_MOVE);
            8'b1010_1???: t = ent(LEN_2, CYC_4, CLS_MOVE);
            8'b0111_1???: t = ent(LEN_2, CYC_2, CLS_MOVE);
            8'hf5: t = ent(LEN_2, CYC_3, CLS_MOVE);
            8'b1000_1???: t = ent(LEN_2, CYC_3, CLS_MOVE);
            8'h85: t = ent(LEN_3, CYC_4, CLS_MOVE);
            8'b1000_011?: t = ent(LEN_2, CYC_4, CLS_MOVE);
            8'h75: t = ent(LEN_3, CYC_3, CLS_MOVE);
            8'b1111_011?: t = ent(LEN_1, CYC_3, CLS_MOVE);
            8'b1010_011?: t = ent(LEN_2, CYC_3, CLS_MOVE);
            8'b0111_011?: t = ent(LEN_2, CYC_3, CLS_MOVE);
            8'h90: t = ent(LEN_3, CYC_3, CLS_MOVE);
            default: t.covered = 1'b0;
        endcase
        return t;
    endfunction

    // code read, auxiliary, stack and exchange group
    function automatic timing_t memory_row(
        input logic [OPC_W-1:0] op
    );
        timing_t t;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        casez (op)
            8'h93: t = ent(LEN_1, CYC_4, CLS_CODE);
            8'h83: t = ent(LEN_1, CYC_4, CLS_CODE);
            8'b1110_001?: t = ent(LEN_1, CYC_3, CLS_AUX);
            8'he0: t = ent(LEN_1, CYC_3, CLS_AUX);
            8'b1111_001?: t = ent(LEN_1, CYC_4, CLS_AUX);
            8'hf0: t = ent(LEN_1, CYC_3, CLS_AUX);
            8'hc0: t = ent(LEN_2, CYC_4, CLS_STACK);
            8'hd0: t = ent(LEN_2, CYC_3, CLS_STACK);
            8'b1100_1???: t = ent(LEN_1, CYC_3, CLS_EXCH);
            8'hc5: t = ent(LEN_2, CYC_4, CLS_EXCH);
            8'b1100_011?: t = ent(LEN_1, CYC_4, CLS_EXCH);
            8'b1101_011?: t = ent(LEN_1, CYC_4, CLS_EXCH);
            default: t.covered = 1'b0;
        endcase
        return t;
    endfunction

    // increment, decrement and multiply group
    function automatic timing_t arith_misc_row(
        input logic [OPC_W-1:0] op
    );
        timing_t t;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        casez (op)
            8'h04: t = ent(LEN_1, CYC_2, CLS_ARITH);
            8'b0000_1???: t = ent(LEN_1, CYC_3, CLS_ARITH);
            8'h05: t = ent(LEN_2, CYC_4, CLS_ARITH);
            8'b0000_011?: t = ent(LEN_1, CYC_4, CLS_ARITH);
            8'h14: t = ent(LEN_1, CYC_2, CLS_ARITH);
            8'b0001_1???: t = ent(LEN_1, CYC_3, CLS_ARITH);
            8'h15: t = ent(LEN_2, CYC_4, CLS_ARITH);
            8'b0001_011?: t = ent(LEN_1, CYC_4, CLS_ARITH);
            8'ha3: t = ent(LEN_1, CYC_1, CLS_ARITH);
            8'ha4: t = ent(LEN_1, CYC_4, CLS_ARITH);
            8'h84: t = ent(LEN_1, CYC_5, CLS_ARITH);
            8'hd4: t = ent(LEN_1, CYC_4, CLS_ARITH);
            default: t.covered = 1'b0;
        endcase
        return t;
    endfunction

    // accumulator logic, rotate and carry group
    function automatic timing_t logic_misc_row(
        input logic [OPC_W-1:0] op
    );
        timing_t t;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        casez (op)
            8'he4: t = ent(LEN_1, CYC_1, CLS_LOGIC);
            8'hf4: t = ent(LEN_1, CYC_2, CLS_LOGIC);
            8'h23: t = ent(LEN_1, CYC_1, CLS_ROTATE);
            8'h33: t = ent(LEN_1, CYC_1, CLS_ROTATE);
            8'h03: t = ent(LEN_1, CYC_1, CLS_ROTATE);
            8'h13: t = ent(LEN_1, CYC_1, CLS_ROTATE);
            8'hc4: t = ent(LEN_1, CYC_1, CLS_ROTATE);
            8'hc3: t = ent(LEN_1, CYC_1, CLS_BOOL);
            8'hc2: t = ent(LEN_2, CYC_4, CLS_BOOL);
            8'hd3: t = ent(LEN_1, CYC_1, CLS_BOOL);
            default: t.covered = 1'b0;
        endcase
        return t;
    endfunction

    // row decode first, then the irregular groups override it
    function automatic timing_t decode_timing(
        input logic [OPC_W-1:0] op
    );
        timing_t t;
        timing_t m;
        timing_t x;
        timing_t a;
        timing_t g;
        t = ent(LEN_1, CYC_1, CLS_NONE);
        t.covered = 1'b0;
        m = move_row(op);
        x = memory_row(op);
        a = arith_misc_row(op);
        g = logic_misc_row(op);
        case (op[7:4])
            4'h2: t = alu_row(op[3:0], CLS_ARITH);
            4'h3: t = alu_row(op[3:0], CLS_ARITH);
            4'h9: t = alu_row(op[3:0], CLS_ARITH);
            4'h4: t = logic_row(op[3:0]);
            4'h5: t = logic_row(op[3:0]);
            4'h6: t = logic_row(op[3:0]);
            default: t.covered = 1'b0;
        endcase
        if (m.covered)
            t = m;
        else if (x.covered)
            t = x;
        else if (a.covered)
            t = a;
        else if (g.covered)
            t = g;
        return t;
    endfunction

    state_t state_q;
    state_t state_d;
    timing_t dec;
    logic [CYC_W-1:0] remaining;
    logic [LEN_W-1:0] needed;
    logic [LEN_W-1:0] needed_next;
    logic advance;
    logic finish;
    logic ready_d;
    logic done_d;
    logic stall_d;

    assign dec = decode_timing(code_byte_in);

    wire logic in_fetch = (state_q == ST_FETCH);
    wire logic in_exec = (state_q == ST_EXEC);
    wire logic take_opcode = in_fetch & code_ready_out & code_valid_in;
    wire logic take_operand = in_exec & code_ready_out & code_valid_in;
    wire logic single_cycle = (dec.cyc == CYC_1);
    wire logic is_aux = (dec.cls == CLS_AUX);

    cycle_budget_counter #(
        .CW(CYC_W),
        .LW(LEN_W)
    ) u_budget (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(take_opcode),
        .cycles_in(dec.cyc),
        .bytes_in(dec.len),
        .operand_in(take_operand),
        .remaining_out(remaining),
        .needed_out(needed),
        .needed_next_out(needed_next),
        .advance_out(advance),
        .finish_out(finish)
    );

    operand_byte_latch #(
        .BW(OPC_W),
        .OW(OPS_W)
    ) u_operands (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(take_opcode),
        .take_in(take_operand),
        .byte_in(code_byte_in),
        .operands_out(instr_operands_out)
    );

    // one clock per execution cycle; fetch resumes right after the last
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_FETCH:
            begin
                if (take_opcode && !single_cycle)
                    state_d = ST_EXEC;
            end
            ST_EXEC:
            begin
                if (finish)
                    state_d = ST_FETCH;
            end
            default: state_d = ST_FETCH;
        endcase
    end

    assign ready_d = (state_d == ST_FETCH) | (needed_next != LEN_0);
    assign done_d = (take_opcode & single_cycle) | finish;
    assign stall_d = in_exec & ~advance & (remaining != CYC_0);

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_FETCH;
            code_ready_out <= 1'b1;
            instr_start_out <= 1'b0;
            instr_done_out <= 1'b0;
            operand_stall_out <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            code_ready_out <= ready_d;
            instr_start_out <= take_opcode;
            instr_done_out <= done_d;
            operand_stall_out <= stall_d;
        end
    end

    // decoded attributes held for the whole instruction
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            instr_opcode_out <= RST_OPCODE;
            instr_length_out <= LEN_0;
            instr_cycles_out <= CYC_0;
            instr_class_out <= CLS_NONE;
            instr_covered_out <= 1'b0;
            instr_reserved_out <= 1'b0;
            aux_onchip_out <= 1'b0;
        end
        else if (take_opcode)
        begin
            instr_opcode_out <= code_byte_in;
            instr_length_out <= dec.len;
            instr_cycles_out <= dec.cyc;
            instr_class_out <= dec.cls;
            instr_covered_out <= dec.covered;
            instr_reserved_out <= (code_byte_in == RESERVED_OPCODE);
            aux_onchip_out <= is_aux;
        end
    end

    // auxiliary moves always stay on chip
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ext_mem_req_out <= 1'b0;
        else
            ext_mem_req_out <= 1'b0;
    end

endmodule // core_instruction_length_timing
`default_nettype wire

// [core_timing_pkg.sv]
`default_nettype none
package core_timing_pkg;
    localparam int OPC_W = 8;
    localparam int LEN_W = 2;
    localparam int CYC_W = 3;
    localparam int OPS_W = 16;

    localparam logic [LEN_W-1:0] LEN_0 = 2'h0;
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;
    localparam logic [CYC_W-1:0] CYC_0 = 3'h0;
    localparam logic [CYC_W-1:0] CYC_1 = 3'h1;
    localparam logic [CYC_W-1:0] CYC_2 = 3'h2;
    localparam logic [CYC_W-1:0] CYC_3 = 3'h3;
    localparam logic [CYC_W-1:0] CYC_4 = 3'h4;
    localparam logic [CYC_W-1:0] CYC_5 = 3'h5;

    localparam logic [OPC_W-1:0] RST_OPCODE = 8'h00;
    localparam logic [OPS_W-1:0] RST_OPERANDS = 16'h0000;
    localparam logic [OPC_W-1:0] RESERVED_OPCODE = 8'ha5;

    // operand mode by low opcode nibble in the regular rows
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND0 = 4'h6;
    localparam logic [3:0] LO_IND1 = 4'h7;
    localparam logic [3:0] LO_DIR_ACC = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;

    typedef enum logic [9:0] {
        CLS_NONE = 10'h001,
        CLS_MOVE = 10'h002,
        CLS_ARITH = 10'h004,
        CLS_LOGIC = 10'h008,
        CLS_ROTATE = 10'h010,
        CLS_AUX = 10'h020,
        CLS_CODE = 10'h040,
        CLS_STACK = 10'h080,
        CLS_EXCH = 10'h100,
        CLS_BOOL = 10'h200
    } cls_t;

    typedef enum logic [1:0] {
        ST_FETCH = 2'h1,
        ST_EXEC = 2'h2
    } state_t;

    typedef struct packed {
        logic covered;
        logic [LEN_W-1:0] len;
        logic [CYC_W-1:0] cyc;
        cls_t cls;
    } timing_t;
endpackage
`default_nettype wire

// [cycle_budget_counter.sv]
`default_nettype none
module cycle_budget_counter
    import core_timing_pkg::*;
#(
    parameter int CW = CYC_W,
    parameter int LW = LEN_W
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic [CW-1:0] cycles_in,
    input wire logic [LW-1:0] bytes_in,
    input wire logic operand_in,
    output logic [CW-1:0] remaining_out,
    output logic [LW-1:0] needed_out,
    output logic [LW-1:0] needed_next_out,
    output logic advance_out,
    output logic finish_out
);
    logic [CW-1:0] rem_d;
    wire logic active = (remaining_out != '0);
    // a cycle may pass only if enough cycles remain for the missing bytes
    assign advance_out = active & ((remaining_out > CW'(needed_out)) | operand_in);
    assign finish_out = (remaining_out == CW'(1)) & advance_out;
    assign needed_next_out = load_in ? LW'(bytes_in - 1'b1)
                                     : LW'(needed_out - LW'(operand_in));
    assign rem_d = load_in ? CW'(cycles_in - 1'b1)
                           : (advance_out ? CW'(remaining_out - 1'b1) : remaining_out);

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            remaining_out <= '0;
            needed_out <= '0;
        end
        else
        begin
            remaining_out <= rem_d;
            needed_out <= needed_next_out;
        end
    end
endmodule // cycle_budget_counter
`default_nettype wire

// [operand_byte_latch.sv]
`default_nettype none
module operand_byte_latch
    import core_timing_pkg::*;
#(
    parameter int BW = OPC_W,
    parameter int OW = OPS_W
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic take_in,
    input wire logic [BW-1:0] byte_in,
    output logic [OW-1:0] operands_out
);
    // earlier bytes move up as later ones arrive
    wire logic [OW-1:0] shifted = {operands_out[OW-BW-1:0], byte_in};
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            operands_out <= RST_OPERANDS;
        else if (clear_in)
            operands_out <= RST_OPERANDS;
        else if (take_in)
            operands_out <= shifted;
    end
endmodule // operand_byte_latch
`default_nettype wire

// [core_timing_checker_asserts.sv]
`default_nettype none
module core_timing_checker
    import core_timing_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic code_valid_in,
    input wire logic code_ready_out,
    input wire logic instr_start_out,
    input wire logic instr_done_out,
    input wire logic [LEN_W-1:0] instr_length_out,
    input wire logic [CYC_W-1:0] instr_cycles_out,
    input wire logic [9:0] instr_class_out,
    input wire logic aux_onchip_out,
    input wire logic ext_mem_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire one_byte = instr_start_out && instr_length_out == LEN_1;

    a_no_ext_cycle: assert property (ext_mem_req_out == 1'b0)
        else $error("external memory cycle raised");
    a_start_after_take: assert property (
        instr_start_out |-> $past(code_valid_in && code_ready_out))
        else $error("start without opcode take");
    a_single_cycle_done: assert property (
        instr_start_out && instr_cycles_out == CYC_1 |-> instr_done_out)
        else $error("one cycle instruction not done at once");
    a_two_cycle_done: assert property (
        one_byte && instr_cycles_out == CYC_2 |-> !instr_done_out ##1 instr_done_out)
        else $error("two cycle instruction wrong length");
    a_three_cycle_done: assert property (
        one_byte && instr_cycles_out == CYC_3 |-> !instr_done_out [*2] ##1 instr_done_out)
        else $error("three cycle instruction wrong length");
    a_four_cycle_done: assert property (
        one_byte && instr_cycles_out == CYC_4 |-> !instr_done_out [*3] ##1 instr_done_out)
        else $error("four cycle instruction wrong length");
    a_exec_refuses_byte: assert property (
        one_byte && instr_cycles_out != CYC_1 |-> !code_ready_out)
        else $error("byte accepted during execution");
    a_aux_one_byte: assert property (aux_onchip_out |-> instr_length_out == LEN_1)
        else $error("auxiliary move not one byte");
    a_rotate_shape: assert property (
        instr_start_out && instr_class_out == CLS_ROTATE |-> one_byte && instr_done_out)
        else $error("rotate or swap shape wrong");
    a_code_read_shape: assert property (
        instr_start_out && instr_class_out == CLS_CODE |-> one_byte
        && instr_cycles_out == CYC_4)
        else $error("code read shape wrong");

    cover property (instr_start_out && instr_length_out == LEN_3);
    cover property (instr_start_out && aux_onchip_out);
    cover property (instr_start_out && instr_done_out);
endmodule // core_timing_checker

bind core_instruction_length_timing core_timing_checker core_timing_checker_inst (
    .ref_clk_in, .rst_n_in, .code_valid_in, .code_ready_out, .instr_start_out,
    .instr_done_out, .instr_length_out, .instr_cycles_out, .instr_class_out,
    .aux_onchip_out, .ext_mem_req_out
);
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench
    import core_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic code_valid_in = 1'b0;
    logic [OPC_W-1:0] code_byte_in = 8'h00;
    logic code_ready_out, instr_start_out, instr_done_out, instr_covered_out;
    logic instr_reserved_out, operand_stall_out, aux_onchip_out, ext_mem_req_out;
    logic [OPC_W-1:0] instr_opcode_out;
    logic [OPS_W-1:0] instr_operands_out;
    logic [LEN_W-1:0] instr_length_out;
    logic [CYC_W-1:0] instr_cycles_out;
    logic [9:0] instr_class_out;
    int n_errors = 0;
    int comparisons = 0;

    always #10 ref_clk_in = ~ref_clk_in;

    core_instruction_length_timing core_instruction_length_timing_inst (
        .ref_clk_in, .rst_n_in, .code_valid_in, .code_byte_in, .code_ready_out,
        .instr_start_out, .instr_done_out, .instr_opcode_out, .instr_operands_out,
        .instr_length_out, .instr_cycles_out, .instr_class_out, .instr_covered_out,
        .instr_reserved_out, .operand_stall_out, .aux_onchip_out, .ext_mem_req_out
    );

    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic idle_state();
        check_bit("ready", 1'b1, code_ready_out);
        check_bit("start", 1'b0, instr_start_out);
        check_val("class", 16'(CLS_NONE), 16'(instr_class_out));
        check_bit("ext", 1'b0, ext_mem_req_out);
    endtask

    // opcode, operands on following edges, last operand held back by late cycles
    task automatic run(input logic [7:0] op, input logic [1:0] len, input logic [2:0] cyc,
        input cls_t cls, input int late);
        int e;
        int stalls = 0;
        @(posedge ref_clk_in);
        code_valid_in <= 1'b1;
        code_byte_in <= op;
        @(posedge ref_clk_in);
        for (e = 0; e < 12; e++)
        begin
            code_valid_in <= (e + 1 < len - 1) || (len > 1 && e + 1 == len - 1 + late);
            code_byte_in <= (e + 1 < len - 1) ? 8'h3c : 8'hc5;
            #1;
            if (e == 0)
            begin
                check_bit("start", 1'b1, instr_start_out);
                check_val("length", 16'(len), 16'(instr_length_out));
                check_val("cycles", 16'(cyc), 16'(instr_cycles_out));
                check_val("class", 16'(cls), 16'(instr_class_out));
                check_bit("covered", cls != CLS_NONE, instr_covered_out);
                check_bit("ready", len > 1 || cyc == 3'h1, code_ready_out);
                check_bit("aux", cls == CLS_AUX, aux_onchip_out);
                check_val("opcode", 16'(op), 16'(instr_opcode_out));
                check_bit("reserved", op == 8'ha5, instr_reserved_out);
            end
            if (operand_stall_out === 1'b1)
                stalls++;
            if (instr_done_out === 1'b1)
                break;
            @(posedge ref_clk_in);
        end
        if (e == 12)
        begin
            n_errors++;
            finish_test();
        end
        else
        begin
            check_val("elapsed", 16'(cyc - 1 + late), 16'(e));
            check_val("stalls", 16'(late), 16'(stalls));
            check_val("operands", len == 3 ? 16'h3cc5 : len == 2 ? 16'h00c5 : 16'h0000,
                instr_operands_out);
            check_bit("ext", 1'b0, ext_mem_req_out);
        end
    endtask

    task automatic back_to_back();
        @(posedge ref_clk_in);
        code_valid_in <= 1'b1;
        code_byte_in <= 8'hf8;
        @(posedge ref_clk_in);
        code_byte_in <= 8'h03;
        #1;
        check_bit("ready", 1'b0, code_ready_out);
        @(posedge ref_clk_in);
        #1;
        check_bit("done", 1'b1, instr_done_out);
        check_bit("start", 1'b0, instr_start_out);
        @(posedge ref_clk_in);
        code_byte_in <= 8'hc4;
        #1;
        check_val("opcode", 16'h0003, 16'(instr_opcode_out));
        check_bit("done", 1'b1, instr_done_out);
        @(posedge ref_clk_in);
        code_valid_in <= 1'b0;
        #1;
        check_val("opcode", 16'h00c4, 16'(instr_opcode_out));
        check_bit("done", 1'b1, instr_done_out);
    endtask

    task automatic mid_reset();
        @(posedge ref_clk_in);
        code_valid_in <= 1'b1;
        code_byte_in <= 8'ha8;
        @(posedge ref_clk_in);
        code_valid_in <= 1'b0;
        rst_n_in <= 1'b0;
        #1;
        idle_state();
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
    endtask

    initial
    begin
        repeat (7) @(posedge ref_clk_in);
        #1;
        idle_state();
        @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        run(8'he8, 2'h1, 3'h1, CLS_MOVE, 0);
        run(8'hf8, 2'h1, 3'h2, CLS_MOVE, 0);
        run(8'ha8, 2'h2, 3'h4, CLS_MOVE, 0);
        run(8'h85, 2'h3, 3'h4, CLS_MOVE, 0);
        run(8'h75, 2'h3, 3'h3, CLS_MOVE, 0);
        run(8'h75, 2'h3, 3'h3, CLS_MOVE, 1);
        run(8'ha6, 2'h2, 3'h3, CLS_MOVE, 0);
        run(8'h90, 2'h3, 3'h3, CLS_MOVE, 2);
        run(8'h93, 2'h1, 3'h4, CLS_CODE, 0);
        run(8'h83, 2'h1, 3'h4, CLS_CODE, 0);
        run(8'he3, 2'h1, 3'h3, CLS_AUX, 0);
        run(8'he0, 2'h1, 3'h3, CLS_AUX, 0);
        run(8'hf2, 2'h1, 3'h4, CLS_AUX, 0);
        run(8'hf0, 2'h1, 3'h3, CLS_AUX, 0);
        run(8'hc0, 2'h2, 3'h4, CLS_STACK, 0);
        run(8'hd0, 2'h2, 3'h3, CLS_STACK, 0);
        run(8'hc5, 2'h2, 3'h4, CLS_EXCH, 0);
        run(8'hd6, 2'h1, 3'h4, CLS_EXCH, 0);
        run(8'h28, 2'h1, 3'h2, CLS_ARITH, 0);
        run(8'h24, 2'h2, 3'h2, CLS_ARITH, 0);
        run(8'h35, 2'h2, 3'h3, CLS_ARITH, 0);
        run(8'h96, 2'h1, 3'h3, CLS_ARITH, 0);
        run(8'h5f, 2'h1, 3'h2, CLS_LOGIC, 0);
        run(8'h44, 2'h2, 3'h2, CLS_LOGIC, 0);
        run(8'h65, 2'h2, 3'h3, CLS_LOGIC, 0);
        run(8'h47, 2'h1, 3'h3, CLS_LOGIC, 0);
        run(8'h52, 2'h2, 3'h4, CLS_LOGIC, 0);
        run(8'h63, 2'h3, 3'h4, CLS_LOGIC, 0);
        run(8'h03, 2'h1, 3'h1, CLS_ROTATE, 0);
        run(8'h13, 2'h1, 3'h1, CLS_ROTATE, 0);
        run(8'h23, 2'h1, 3'h1, CLS_ROTATE, 0);
        run(8'h33, 2'h1, 3'h1, CLS_ROTATE, 0);
        run(8'hc4, 2'h1, 3'h1, CLS_ROTATE, 0);
        run(8'hc2, 2'h2, 3'h4, CLS_BOOL, 0);
        run(8'h84, 2'h1, 3'h5, CLS_ARITH, 0);
        run(8'he4, 2'h1, 3'h1, CLS_LOGIC, 0);
        run(8'ha5, 2'h1, 3'h1, CLS_NONE, 0);
        check_bit("reserved", 1'b1, instr_reserved_out);
        back_to_back();
        mid_reset();
        run(8'he8, 2'h1, 3'h1, CLS_MOVE, 0);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
